// ===== nvmseq_cpu_model.sv
/*
 * nvmseq_cpu_model: core side of the register port and the table port.
 * Assumes the bench calls its tasks one at a time, off or on a rising edge.
 */
`timescale 1ns/1ps

module nvmseq_cpu_model
    import nvmseq_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    // table port
    output logic tbl_valid,
    output logic tbl_write,
    output logic [23:0] tbl_ea,
    output logic [15:0] tbl_wdata
);
    // expected read answers, oldest first
    logic [15:0] reg_q[$];
    logic [15:0] tbl_q[$];

    // idle levels at time zero
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {tbl_valid, tbl_write, tbl_ea, tbl_wdata} = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one strobe cycle; released lines flip so stale values never look valid
    task automatic reg_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic reg_read(input logic [15:0] a, input logic [15:0] e);
        reg_q.push_back(e);
        reg_op(1'b0, a, 16'h0000);
    endtask

    task automatic tbl_op(input logic wr, input logic [23:0] ea, input logic [15:0] d);
        @(posedge clk);
        tbl_valid <= 1'b1;
        tbl_write <= wr;
        tbl_ea <= ea;
        tbl_wdata <= d;
        @(posedge clk);
        tbl_valid <= 1'b0;
        tbl_ea <= ~ea;
        tbl_wdata <= ~d;
    endtask

    task automatic tbl_read(input logic [23:0] ea, input logic [15:0] e);
        tbl_q.push_back(e);
        tbl_op(1'b0, ea, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // key pair then start, no other register write between them
    // the idle edge after each strobe stands in for the two no-operations
    task automatic start_op(input logic [15:0] ctl);
        reg_op(1'b1, NVMSEQ_KEY_OFS, {8'h00, NVMSEQ_KEY_FIRST});
        reg_op(1'b1, NVMSEQ_KEY_OFS, {8'h00, NVMSEQ_KEY_SECOND});
        reg_op(1'b1, NVMSEQ_CONTROL_OFS, ctl | 16'h8000);
    endtask
endmodule // nvmseq_cpu_model

// ===== nvmseq_pkg.sv
/*
 * nvmseq_pkg: constants and types of the non-volatile memory unlock sequencer.
 * Assumes a 250 MHz system clock and a 16-bit register port with 16-bit addresses.
 */
package nvmseq_pkg;

    // register offsets
    localparam logic [15:0] NVMSEQ_ADR_LOW_OFS = 16'h0762;
    localparam logic [15:0] NVMSEQ_ADR_UPPER_OFS = 16'h0764;
    localparam logic [15:0] NVMSEQ_STATUS_OFS = 16'h0766;
    localparam logic [15:0] NVMSEQ_CONTROL_OFS = 16'h0920;
    localparam logic [15:0] NVMSEQ_KEY_OFS = 16'h9920;

    // control register bit positions, and the done bit of the status register
    localparam int NVMSEQ_WR_BIT = 15;
    localparam int NVMSEQ_WR_EN_BIT = 14;
    localparam int NVMSEQ_WR_ERR_BIT = 13;
    localparam int NVMSEQ_TERM_BIT = 8;
    localparam int NVMSEQ_OP_MSB = 6;
    localparam int NVMSEQ_DONE_BIT = 0;

    // reset values
    localparam logic [15:0] NVMSEQ_CONTROL_RST = 16'h0000;
    localparam logic [23:0] NVMSEQ_ADR_RST = 24'h000000;

    // unlock keys (low byte of the key register)
    localparam logic [7:0] NVMSEQ_KEY_FIRST = 8'h55;
    localparam logic [7:0] NVMSEQ_KEY_SECOND = 8'haa;

    // operation codes of the operation select field
    localparam logic [6:0] NVMSEQ_OP_EE_WORD_ERASE = 7'h44;
    localparam logic [6:0] NVMSEQ_OP_EE_BLOCK_ERASE = 7'h45;
    localparam logic [6:0] NVMSEQ_OP_EE_WORD_PROG = 7'h04;
    localparam logic [6:0] NVMSEQ_OP_EE_BLOCK_PROG = 7'h0a;
    localparam logic [6:0] NVMSEQ_OP_PF_ROW_ERASE = 7'h41;
    localparam logic [6:0] NVMSEQ_OP_PF_ROW_PROG = 7'h01;

    // data eeprom window in program space
    localparam logic [23:0] NVMSEQ_EE_BASE = 24'h7ff000;
    localparam logic [23:0] NVMSEQ_EE_LAST = 24'h7ffffe;
    localparam int NVMSEQ_EE_WORDS = 2048;
    localparam int NVMSEQ_BLOCK_WORDS = 16;
    localparam logic [15:0] NVMSEQ_ERASED_WORD = 16'hffff;
    localparam logic [15:0] NVMSEQ_UNSPEC_WORD = 16'hffff;

    // cycle timing
    localparam int NVMSEQ_CLK_PERIOD_NS = 4;
    localparam int NVMSEQ_EE_CYCLE_NS = 2000000;
    localparam int NVMSEQ_PF_CYCLE_NS = 2000000;
    localparam int NVMSEQ_EE_CYCLES = NVMSEQ_EE_CYCLE_NS / NVMSEQ_CLK_PERIOD_NS;
    localparam int NVMSEQ_PF_CYCLES = NVMSEQ_PF_CYCLE_NS / NVMSEQ_CLK_PERIOD_NS;

    // unlock progress
    typedef enum logic [1:0] {
        NVMSEQ_KEY_IDLE,
        NVMSEQ_KEY_HALF,
        NVMSEQ_KEY_ARMED
    } nvmseq_key_type;

endpackage

// ===== nvmseq_sequencer.sv
/*
 * nvmseq_sequencer: unlock, start and timing of data eeprom and program flash
 * erase and program cycles, with the data eeprom array, its write latches and
 * table read/write handling.
 * Assumes the cpu core drives the register port and the table port on clk,
 * rst_n covers every system reset, por_n only power-up, and the reset
 * controller holds its cause levels steady around the release of rst_n.
 */
`timescale 1ns/1ps

module nvmseq_sequencer
    import nvmseq_pkg::*;
#(
    parameter int EE_CYCLES = NVMSEQ_EE_CYCLES,
    parameter int PF_CYCLES = NVMSEQ_PF_CYCLES
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    // cause of the last system reset, levels from the reset controller
    input wire logic rst_cause_master_clear,
    input wire logic rst_cause_watchdog,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // table instruction port
    input wire logic tbl_valid,
    input wire logic tbl_write,
    input wire logic [23:0] tbl_ea,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    // status to the core
    output logic cpu_stall,
    output logic nvm_busy,
    output logic nvm_done_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        nvmseq_key_type key;
        logic wr;
        logic wr_en;
        logic err;
        logic term;
        logic [6:0] op;
        logic run;
        logic stall;
        logic [6:0] run_op;
        logic [10:0] run_idx;
        logic [31:0] cnt;
        logic done;
        logic alive;
        logic [15:0] rdata;
        logic [15:0] tdata;
        logic tvalid;
        logic [15:0][15:0] latch;
    } nvmseq_state_type;

    // survives system resets, cleared only at power-up
    typedef struct packed {
        logic [23:0] adr;
        logic busy;
    } nvmseq_keep_type;

    nvmseq_state_type s_q, s_d;
    nvmseq_keep_type k_q, k_d;
    logic [15:0] ee_mem [NVMSEQ_EE_WORDS];

    logic ctl_wr;
    logic key_wr;
    logic start_try;
    logic start_ok;
    logic fin;
    logic run_is_pf;
    logic op_is_pf;
    logic tbl_in_ee;
    logic [10:0] tbl_idx;
    logic [10:0] adr_idx;
    logic [23:0] tbl_off;
    logic [23:0] adr_off;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // address of a table access and of the held address, inside the window
    assign tbl_off = tbl_ea - NVMSEQ_EE_BASE;
    assign adr_off = k_q.adr - NVMSEQ_EE_BASE;
    assign tbl_idx = tbl_off[11:1];
    assign adr_idx = adr_off[11:1];
    assign tbl_in_ee = (tbl_ea >= NVMSEQ_EE_BASE) && (tbl_ea <= NVMSEQ_EE_LAST);

    assign ctl_wr = reg_wr && (reg_addr == NVMSEQ_CONTROL_OFS);
    assign key_wr = reg_wr && (reg_addr == NVMSEQ_KEY_OFS);
    // write enable must already be set; the same write cannot set both
    assign start_try = ctl_wr && reg_wdata[NVMSEQ_WR_BIT];
    assign start_ok = start_try && (s_q.key == NVMSEQ_KEY_ARMED) && s_q.wr_en
        && !s_q.run;
    assign fin = s_q.run && (s_q.cnt == 32'h0000_0001);
    assign op_is_pf = (s_q.op == NVMSEQ_OP_PF_ROW_ERASE) || (s_q.op == NVMSEQ_OP_PF_ROW_PROG);
    assign run_is_pf = (s_q.run_op == NVMSEQ_OP_PF_ROW_ERASE)
        || (s_q.run_op == NVMSEQ_OP_PF_ROW_PROG);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        k_d = k_q;
        s_d.alive = 1'b1;
        s_d.tvalid = 1'b0;
        s_d.rdata = 16'h0000;

        // unlock tracker: keys must follow each other with no other write
        if (reg_wr) begin
            s_d.key = NVMSEQ_KEY_IDLE;
            if (key_wr && reg_wdata[7:0] == NVMSEQ_KEY_FIRST) begin
                s_d.key = NVMSEQ_KEY_HALF;
            end else if (key_wr && reg_wdata[7:0] == NVMSEQ_KEY_SECOND
                         && s_q.key == NVMSEQ_KEY_HALF) begin
                s_d.key = NVMSEQ_KEY_ARMED;
            end
        end

        // control register; the start bit is never cleared by software
        if (ctl_wr) begin
            s_d.wr_en = reg_wdata[NVMSEQ_WR_EN_BIT];
            s_d.err = reg_wdata[NVMSEQ_WR_ERR_BIT];
            s_d.term = reg_wdata[NVMSEQ_TERM_BIT];
            if (!s_q.run) begin
                s_d.op = reg_wdata[NVMSEQ_OP_MSB:0];
            end
        end

        // launch; op and address are frozen so later writes cannot disturb it
        if (start_ok) begin
            s_d.wr = 1'b1;
            s_d.run = 1'b1;
            s_d.run_op = s_q.op;
            s_d.run_idx = adr_idx;
            s_d.cnt = op_is_pf ? PF_CYCLES : EE_CYCLES;
            s_d.stall = op_is_pf;
        end else if (s_q.run) begin
            s_d.cnt = s_q.cnt - 32'h0000_0001;
            if (fin) begin
                s_d.wr = 1'b0;
                s_d.run = 1'b0;
                s_d.stall = 1'b0;
                s_d.done = 1'b1;
            end
        end

        // done flag: write one to clear, a completion in that cycle wins
        if (reg_wr && reg_addr == NVMSEQ_STATUS_OFS && reg_wdata[NVMSEQ_DONE_BIT]
            && !fin) begin
            s_d.done = 1'b0;
        end

        // first cycle after a system reset release: was a write cut short?
        if (!s_q.alive && k_q.busy && (rst_cause_master_clear || rst_cause_watchdog)) begin
            s_d.err = 1'b1;
        end

        // in-progress marker: follows the run only once out of reset; the held address always follows the core
        if (s_q.alive) begin
            k_d.busy = s_d.run;
        end
        if (tbl_valid) begin
            k_d.adr = tbl_ea;
        end
        if (reg_wr && reg_addr == NVMSEQ_ADR_LOW_OFS) begin
            k_d.adr[15:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == NVMSEQ_ADR_UPPER_OFS) begin
            k_d.adr[23:16] = reg_wdata[7:0];
        end

        // table access: writes fill a latch, reads return the array word
        if (tbl_valid && tbl_in_ee) begin
            if (tbl_write) begin
                s_d.latch[tbl_idx[3:0]] = tbl_wdata;
            end else begin
                s_d.tvalid = 1'b1;
                // array contents are not defined while it is being changed
                s_d.tdata = s_q.run ? NVMSEQ_UNSPEC_WORD : ee_mem[tbl_idx];
            end
        end

        // register read, answered in the next cycle
        if (reg_rd) begin
            case (reg_addr)
                NVMSEQ_CONTROL_OFS: begin
                    s_d.rdata = {s_q.wr, s_q.wr_en, s_q.err, 4'h0, s_q.term, 1'b0, s_q.op};
                end
                NVMSEQ_ADR_LOW_OFS: begin
                    s_d.rdata = k_q.adr[15:0];
                end
                NVMSEQ_ADR_UPPER_OFS: begin
                    s_d.rdata = {8'h00, k_q.adr[23:16]};
                end
                NVMSEQ_STATUS_OFS: begin
                    s_d.rdata = {13'h0000, s_q.stall, s_q.run, s_q.done};
                end
                default: begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // every system reset clears control, including write enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // address and in-progress marker ride through system resets
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            k_q <= '{adr: NVMSEQ_ADR_RST, busy: 1'b0};
        end else begin
            k_q <= k_d;
        end
    end

    // array update at the end of a data eeprom cycle
    always_ff @(posedge clk) begin
        if (fin) begin
            for (int i = 0; i < NVMSEQ_BLOCK_WORDS; i++) begin
                case (s_q.run_op)
                    NVMSEQ_OP_EE_WORD_ERASE: begin
                        if (i == 0) begin
                            ee_mem[s_q.run_idx] <= NVMSEQ_ERASED_WORD;
                        end
                    end
                    NVMSEQ_OP_EE_WORD_PROG: begin
                        if (i == 0) begin
                            ee_mem[s_q.run_idx] <= s_q.latch[s_q.run_idx[3:0]];
                        end
                    end
                    NVMSEQ_OP_EE_BLOCK_ERASE: begin
                        ee_mem[{s_q.run_idx[10:4], i[3:0]}] <= NVMSEQ_ERASED_WORD;
                    end
                    NVMSEQ_OP_EE_BLOCK_PROG: begin
                        ee_mem[{s_q.run_idx[10:4], i[3:0]}] <= s_q.latch[i[3:0]];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = s_q.rdata;
    assign tbl_rdata = s_q.tdata;
    assign tbl_rvalid = s_q.tvalid;
    assign cpu_stall = s_q.stall;
    assign nvm_busy = s_q.wr;
    assign nvm_done_flag = s_q.done;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_start_keyed: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.run) |-> $past(s_q.key) == NVMSEQ_KEY_ARMED && $past(s_q.wr_en))
        else $error("operation started without unlock or write enable");

    chk_wr_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.wr && !fin |=> s_q.wr)
        else $error("start bit dropped before the cycle ended");

    chk_end_clears: assert property (@(posedge clk) disable iff (!rst_n)
        fin |=> !s_q.wr && s_q.done && !s_q.stall)
        else $error("end of cycle did not clear start bit and set done");

    chk_ee_duration: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.run) && !run_is_pf |-> s_q.cnt == EE_CYCLES)
        else $error("data eeprom cycle length wrong");

    chk_ee_no_stall: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.run && !run_is_pf |-> !cpu_stall)
        else $error("core stalled during a data eeprom cycle");

    chk_pf_stall: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.run && run_is_pf |-> cpu_stall && s_q.cnt <= PF_CYCLES)
        else $error("program flash cycle without stall");

    chk_key_cancel: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && !key_wr |=> s_q.key == NVMSEQ_KEY_IDLE)
        else $error("unlock survived an unrelated write");

    chk_no_write_enable: assert property (@(posedge clk) disable iff (!rst_n)
        start_try && !s_q.wr_en && !s_q.run |=> !s_q.wr && !s_q.run)
        else $error("start accepted with write enable clear");

    chk_tbl_capture: assert property (@(posedge clk) disable iff (!por_n)
        tbl_valid && !reg_wr |=> k_q.adr == $past(tbl_ea))
        else $error("table address not captured");

    chk_busy_read: assert property (@(posedge clk) disable iff (!rst_n)
        tbl_valid && !tbl_write && tbl_in_ee && s_q.run |=> tbl_rvalid
            && tbl_rdata == NVMSEQ_UNSPEC_WORD)
        else $error("table read during a cycle not flagged");

    chk_err_reset: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.alive && k_q.busy && rst_cause_watchdog |=> s_q.err)
        else $error("interrupted write left no error flag");

    cov_block_erase: cover property (@(posedge clk) disable iff (!rst_n)
        start_ok && s_q.op == NVMSEQ_OP_EE_BLOCK_ERASE);

    cov_word_prog_done: cover property (@(posedge clk) disable iff (!rst_n)
        fin && s_q.run_op == NVMSEQ_OP_EE_WORD_PROG);

    cov_key_broken: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.key == NVMSEQ_KEY_HALF && reg_wr && !key_wr);

    cov_err_set: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.err) && !$past(s_q.alive));

endmodule // nvmseq_sequencer

// ===== test_nvm_unlock_eeprom_sequencer.sv
/*
 * test_nvm_unlock_eeprom_sequencer: self-checking bench of the sequencer.
 * Assumes nvmseq_pkg, nvmseq_sequencer and nvmseq_cpu_model compiled first.
 */
`timescale 1ns/1ps

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module test_nvm_unlock_eeprom_sequencer
    import nvmseq_pkg::*;
();
    // short cycle counts keep the run brief
    localparam int EE_N = 20;
    localparam int PF_N = 12;
    logic clk, rst_n, por_n, cause_clr, cause_wdog, reg_wr, reg_rd, tbl_valid, tbl_write;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, tbl_wdata, tbl_rdata, e, t;
    logic [23:0] tbl_ea;
    logic tbl_rvalid, cpu_stall, nvm_busy, nvm_done_flag;
    logic rd_d = 1'b0;
    logic [15:0] dat [16];
    logic [31:0] rng = 32'h565e9996;
    int failures = 0;
    int num_checks = 0;

    // system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    nvmseq_sequencer #(.EE_CYCLES(EE_N), .PF_CYCLES(PF_N)) u_dut (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .rst_cause_master_clear(cause_clr),
        .rst_cause_watchdog(cause_wdog), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_ea(tbl_ea),
        .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
        .cpu_stall(cpu_stall), .nvm_busy(nvm_busy), .nvm_done_flag(nvm_done_flag));

    nvmseq_cpu_model u_cpu (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
        .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // answers are matched against the oldest note; sampled before the edge lands
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            e = u_cpu.reg_q.pop_front();
            `CHK("reg_rdata", e, reg_rdata)
        end
        if (tbl_rvalid) begin
            t = u_cpu.tbl_q.pop_front();
            `CHK("tbl_rdata", t, tbl_rdata)
        end
    end

    // busy for exactly n edges, stall as given, done at the end
    task automatic run_check(input int n, input logic stall);
        int c;
        // called on the start edge: step off it so busy counts from that edge
        #1;
        c = 0;
        while (nvm_busy !== 1'b1 && c < 4) begin
            @(posedge clk);
            #1;
            c++;
        end
        `CHK("busy", 1'b1, nvm_busy)
        c = 0;
        while (nvm_busy === 1'b1 && c < 1000) begin
            `CHK("stall", stall, cpu_stall)
            @(posedge clk);
            #1;
            c++;
        end
        `CHK("cycle length", n, c)
        `CHK("done", 1'b1, nvm_done_flag)
    endtask

    // only called once the earlier cycle has ended
    task automatic launch(input logic [15:0] ctl);
        u_cpu.reg_op(1'b1, NVMSEQ_STATUS_OFS, 16'h0001);
        #1;
        `CHK("done clear", 1'b0, nvm_done_flag)
        u_cpu.reg_op(1'b1, NVMSEQ_CONTROL_OFS, ctl);
        u_cpu.start_op(ctl);
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run
    initial begin
        #40000;
        failures++;
        $display("[FAIL] watchdog expected end seen hang");
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, por_n, cause_clr, cause_wdog} = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        u_cpu.reg_read(NVMSEQ_CONTROL_OFS, NVMSEQ_CONTROL_RST);
        u_cpu.reg_read(NVMSEQ_KEY_OFS, 16'h0000);
        u_cpu.reg_read(16'h0100, 16'h0000);
        $display("test reset values done");
        // no keys, swapped keys, broken pair, write enable clear
        for (int v = 0; v < 4; v++) begin
            u_cpu.reg_op(1'b1, NVMSEQ_CONTROL_OFS, (v == 3) ? 16'h0044 : 16'h4044);
            if (v != 0) u_cpu.reg_op(1'b1, NVMSEQ_KEY_OFS, (v == 1) ? 16'h00aa : 16'h0055);
            if (v == 2) u_cpu.reg_op(1'b1, NVMSEQ_ADR_LOW_OFS, 16'h0000);
            if (v != 0) u_cpu.reg_op(1'b1, NVMSEQ_KEY_OFS, (v == 1) ? 16'h0055 : 16'h00aa);
            u_cpu.reg_op(1'b1, NVMSEQ_CONTROL_OFS, (v == 3) ? 16'h8044 : 16'hc044);
            repeat (2) @(posedge clk);
            #1;
            `CHK("refused start", 1'b0, nvm_busy)
            u_cpu.reg_read(NVMSEQ_CONTROL_OFS, (v == 3) ? 16'h0044 : 16'h4044);
        end
        $display("test refused starts done");
        // erase before program at one word
        u_cpu.tbl_op(1'b1, 24'h7ff020, 16'h1234);
        u_cpu.reg_read(NVMSEQ_ADR_LOW_OFS, 16'hf020);
        u_cpu.reg_read(NVMSEQ_ADR_UPPER_OFS, 16'h007f);
        launch(16'h4044);
        fork
            run_check(EE_N, 1'b0);
            begin
                u_cpu.tbl_read(24'h7ff020, NVMSEQ_UNSPEC_WORD);
                u_cpu.reg_op(1'b1, NVMSEQ_CONTROL_OFS, 16'h4044);
            end
        join
        u_cpu.tbl_read(24'h7ff020, NVMSEQ_ERASED_WORD);
        launch(16'h4004);
        run_check(EE_N, 1'b0);
        u_cpu.tbl_read(24'h7ff020, 16'h1234);
        $display("test word erase and program done");
        // random block program, then block erase by direct address
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            dat[i] = rng[15:0];
            u_cpu.tbl_op(1'b1, 24'h7ff040 + 24'(2 * i), rng[15:0]);
        end
        launch(16'h400a);
        run_check(EE_N, 1'b0);
        for (int i = 0; i < 16; i++) u_cpu.tbl_read(24'h7ff040 + 24'(2 * i), dat[i]);
        u_cpu.reg_op(1'b1, NVMSEQ_ADR_UPPER_OFS, 16'h007f);
        u_cpu.reg_op(1'b1, NVMSEQ_ADR_LOW_OFS, 16'hf040);
        launch(16'h4045);
        run_check(EE_N, 1'b0);
        for (int i = 0; i < 16; i++) u_cpu.tbl_read(24'h7ff040 + 24'(2 * i), 16'hffff);
        $display("test block program and erase done");
        launch(16'h4041);
        run_check(PF_N, 1'b1);
        launch(16'h4001);
        run_check(PF_N, 1'b1);
        $display("test flash row erase and program done");
        // reset mid-cycle: master clear, watchdog, then neither cause
        for (int k = 0; k < 3; k++) begin
            u_cpu.tbl_op(1'b1, 24'h7ff0a0 + 24'(4 * k), 16'h0000);
            launch(16'h4044);
            repeat (3) @(posedge clk);
            cause_clr <= (k == 0);
            cause_wdog <= (k == 1);
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            @(posedge clk);
            cause_clr <= 1'b0;
            cause_wdog <= 1'b0;
            u_cpu.reg_read(NVMSEQ_CONTROL_OFS, (k < 2) ? 16'h2000 : 16'h0000);
            u_cpu.reg_read(NVMSEQ_ADR_LOW_OFS, 16'hf0a0 + 16'(4 * k));
        end
        $display("test interrupted write done");
        repeat (3) @(posedge clk);
        `CHK("unanswered", 0, u_cpu.reg_q.size() + u_cpu.tbl_q.size())
        report_and_stop();
    end
endmodule // test_nvm_unlock_eeprom_sequencer
